//--- hdl/adcc_pkg.sv
// Constants and types shared by the converter control logic
package adcc_pkg;

	// Control register address and value after reset
	localparam logic [7:0] ADCC_CONTROL_ADDR  = 8'hE8;
	localparam logic [7:0] ADCC_CONTROL_RESET = 8'h00;

	// Bit positions inside the control register
	localparam int ADCC_BIT_ENABLE = 7;
	localparam int ADCC_BIT_BURST  = 6;
	localparam int ADCC_BIT_DONE   = 5;
	localparam int ADCC_BIT_BUSY   = 4;
	localparam int ADCC_BIT_WINDOW = 3;
	localparam int ADCC_BIT_LJUST  = 2;
	localparam int ADCC_BIT_SRC_HI = 1;
	localparam int ADCC_BIT_SRC_LO = 0;

	// Result width and result register width
	localparam int ADCC_RES_W = 12;
	localparam int ADCC_REG_W = 8;

	// Start-of-conversion source codes
	typedef enum logic [1:0] {
		ADCC_SRC_SW    = 2'b00,
		ADCC_SRC_TMR1  = 2'b01,
		ADCC_SRC_PIN   = 2'b10,
		ADCC_SRC_TMR2  = 2'b11
	} adcc_src_t;

endpackage

//--- hdl/adcc_justify.sv
// Places a conversion result into the high and low result bytes
`timescale 1ns/10ps
`default_nettype none

module adcc_justify (
	input  wire logic [adcc_pkg::ADCC_RES_W-1:0] data,
	input  wire logic                            left,
	output logic      [adcc_pkg::ADCC_REG_W-1:0] high,
	output logic      [adcc_pkg::ADCC_REG_W-1:0] low
);
	import adcc_pkg::*;

	// Left: top eight bits high, remainder padded low; right: zero padded on top
	always_comb begin
		if (left) begin
			high = data[11:4];
			low  = {data[3:0], 4'h0};
		end else begin
			high = {4'h0, data[11:8]};
			low  = data[7:0];
		end
	end

endmodule // adcc_justify

`default_nettype wire

//--- hdl/adcc_control.sv
// Control register, start triggers and flags of the 12-bit converter
`timescale 1ns/10ps
`default_nettype none

module adcc_control (
	input  wire logic                            core_clk,
	input  wire logic                            rstn,
	input  wire logic [7:0]                      sfr_addr,
	input  wire logic                            sfr_wr,
	input  wire logic                            sfr_rd,
	input  wire logic [7:0]                      sfr_wdata,
	output logic      [7:0]                      sfr_rdata,
	input  wire logic                            timer1_ovf,
	input  wire logic                            timer2_ovf,
	input  wire logic                            ext_start_pin,
	input  wire logic                            sar_done,
	input  wire logic [adcc_pkg::ADCC_RES_W-1:0] sar_data,
	input  wire logic                            window_match,
	output logic                                 conv_enable,
	output logic                                 burst_mode_on,
	output logic                                 conv_start,
	output logic                                 conv_busy,
	output logic                                 conv_done_flag,
	output logic                                 window_match_flag,
	output logic      [adcc_pkg::ADCC_REG_W-1:0] result_high,
	output logic      [adcc_pkg::ADCC_REG_W-1:0] result_low
);
	import adcc_pkg::*;

	logic                  left_justify;
	adcc_src_t             start_source_sel;
	logic                  pin_prev;
	logic                  ctl_wr;
	logic                  ctl_rd;
	logic                  next_enable;
	logic                  sw_start;
	logic                  hw_trigger;
	logic                  start_req;
	logic                  conv_end;
	logic [ADCC_REG_W-1:0] just_high;
	logic [ADCC_REG_W-1:0] just_low;

	// Register decode
	assign ctl_wr = sfr_wr && (sfr_addr == ADCC_CONTROL_ADDR);
	assign ctl_rd = sfr_rd && (sfr_addr == ADCC_CONTROL_ADDR);

	// Enable value that takes effect at the coming edge
	assign next_enable = ctl_wr ? sfr_wdata[ADCC_BIT_ENABLE] : conv_enable;

	// Software start uses the source held before this write
	assign sw_start = ctl_wr && sfr_wdata[ADCC_BIT_BUSY]
		&& (start_source_sel == ADCC_SRC_SW);

	// Hardware trigger selected by the source field
	always_comb begin
		hw_trigger = 1'b0;
		unique case (start_source_sel)
			ADCC_SRC_SW:   hw_trigger = 1'b0;
			ADCC_SRC_TMR1: hw_trigger = timer1_ovf;
			ADCC_SRC_PIN:  hw_trigger = ext_start_pin && !pin_prev;
			ADCC_SRC_TMR2: hw_trigger = timer2_ovf;
		endcase
	end

	// A trigger during a running conversion is dropped, not queued
	assign start_req = conv_enable && next_enable && !conv_busy
		&& (sw_start || hw_trigger);
	assign conv_end = conv_busy && sar_done && next_enable;

	// Edge detector history for the external start pin
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= ext_start_pin;
		end
	end

	// Plain configuration bits of the control register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			conv_enable      <= ADCC_CONTROL_RESET[ADCC_BIT_ENABLE];
			burst_mode_on    <= ADCC_CONTROL_RESET[ADCC_BIT_BURST];
			left_justify     <= ADCC_CONTROL_RESET[ADCC_BIT_LJUST];
			start_source_sel <= adcc_src_t'(
				ADCC_CONTROL_RESET[ADCC_BIT_SRC_HI:ADCC_BIT_SRC_LO]);
		end else if (ctl_wr) begin
			conv_enable      <= sfr_wdata[ADCC_BIT_ENABLE];
			burst_mode_on    <= sfr_wdata[ADCC_BIT_BURST];
			left_justify     <= sfr_wdata[ADCC_BIT_LJUST];
			start_source_sel <= adcc_src_t'(
				sfr_wdata[ADCC_BIT_SRC_HI:ADCC_BIT_SRC_LO]);
		end
	end

	// Busy and start pulse; disabling aborts a conversion without a done flag
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			conv_busy  <= ADCC_CONTROL_RESET[ADCC_BIT_BUSY];
			conv_start <= 1'b0;
		end else begin
			conv_start <= start_req;
			if (!next_enable) begin
				conv_busy <= 1'b0;
			end else if (start_req) begin
				conv_busy <= 1'b1;
			end else if (sar_done) begin
				conv_busy <= 1'b0;
			end
		end
	end

	// Done flag: hardware set wins over a software clear in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			conv_done_flag <= ADCC_CONTROL_RESET[ADCC_BIT_DONE];
		end else if (conv_end) begin
			conv_done_flag <= 1'b1;
		end else if (ctl_wr) begin
			conv_done_flag <= sfr_wdata[ADCC_BIT_DONE];
		end
	end

	// Window flag: only software clears it, a match in that cycle still sets
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			window_match_flag <= ADCC_CONTROL_RESET[ADCC_BIT_WINDOW];
		end else if (window_match) begin
			window_match_flag <= 1'b1;
		end else if (ctl_wr) begin
			window_match_flag <= sfr_wdata[ADCC_BIT_WINDOW];
		end
	end

	// Result placement per justify bit
	adcc_justify u_justify (
		.data (sar_data),
		.left (left_justify),
		.high (just_high),
		.low  (just_low)
	);

	// Result bytes load only at a conversion end, so reads stay stable
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			result_high <= '0;
			result_low  <= '0;
		end else if (conv_end) begin
			result_high <= just_high;
			result_low  <= just_low;
		end
	end

	// Read data, one cycle after the strobe; other addresses read zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= 8'h00;
		end else if (ctl_rd) begin
			sfr_rdata <= {conv_enable, burst_mode_on, conv_done_flag,
				conv_busy, window_match_flag, left_justify,
				start_source_sel};
		end else begin
			sfr_rdata <= 8'h00;
		end
	end

	// Checks on the control behaviour
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_idle_armed;
		conv_enable && !conv_busy && !ctl_wr;
	endsequence

	sequence s_started;
		conv_start && conv_busy;
	endsequence

	a_off_no_busy: assert property (
		!conv_enable |-> !conv_busy && !conv_start)
		else $error("busy or start while converter disabled");

	a_sw_start_go: assert property (
		conv_enable && !conv_busy && ctl_wr && sfr_wdata[ADCC_BIT_ENABLE]
		&& sfr_wdata[ADCC_BIT_BUSY] && start_source_sel == ADCC_SRC_SW
		|=> s_started)
		else $error("software start did not begin a conversion");

	a_sw_zero_idle: assert property (
		s_idle_armed ##0 (start_source_sel == ADCC_SRC_SW) |=> !conv_busy)
		else $error("conversion began without a start write");

	a_timer_start: assert property (
		s_idle_armed ##0 ((start_source_sel == ADCC_SRC_TMR1 && timer1_ovf)
		|| (start_source_sel == ADCC_SRC_TMR2 && timer2_ovf))
		|=> s_started)
		else $error("timer overflow did not start a conversion");

	a_pin_edge: assert property (
		s_idle_armed ##0 (start_source_sel == ADCC_SRC_PIN)
		##0 $rose(ext_start_pin) |=> s_started)
		else $error("pin rising edge did not start a conversion");

	a_done_on_fall: assert property (
		conv_busy && sar_done && conv_enable && !ctl_wr
		|=> !conv_busy && conv_done_flag)
		else $error("done flag not set when busy fell");

	a_done_sticky: assert property (
		conv_done_flag && !ctl_wr |=> conv_done_flag)
		else $error("done flag dropped without a clear");

	a_win_set: assert property (
		window_match |=> window_match_flag [*1] ##0
		(window_match_flag || $past(ctl_wr)))
		else $error("window flag not set on match");

	a_win_sticky: assert property (
		window_match_flag && !ctl_wr |=> window_match_flag)
		else $error("window flag cleared by hardware");

	a_burst_bit: assert property (
		ctl_wr |=> burst_mode_on == $past(sfr_wdata[ADCC_BIT_BURST])
		&& conv_enable == $past(sfr_wdata[ADCC_BIT_ENABLE]))
		else $error("burst or enable bit not stored");

	a_left_result: assert property (
		conv_end && left_justify
		|=> result_high == $past(sar_data[11:4])
		&& result_low[3:0] == 4'h0)
		else $error("left justified result misplaced");

	a_right_result: assert property (
		conv_end && !left_justify
		|=> result_high[7:4] == 4'h0 && result_low == $past(sar_data[7:0]))
		else $error("right justified result misplaced");

endmodule // adcc_control

`default_nettype wire

//--- testbench/adcc_control_test.sv
// Self-checking bench for the converter control register and start logic
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
	failures++; $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end

module adcc_control_test;
	import adcc_pkg::*;

	logic        core_clk;
	logic        rstn;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_wdata;
	logic [7:0]  sfr_rdata;
	logic        timer1_ovf;
	logic        timer2_ovf;
	logic        ext_start_pin;
	logic        sar_done;
	logic [11:0] sar_data;
	logic        window_match;
	logic        conv_enable;
	logic        burst_mode_on;
	logic        conv_start;
	logic        conv_busy;
	logic        conv_done_flag;
	logic        window_match_flag;
	logic [7:0]  result_high;
	logic [7:0]  result_low;
	int          failures;
	int          total_checks;
	int          cycles;
	logic [7:0]  v;
	logic [1:0]  code;

	adcc_control DUT (
		.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .timer1_ovf(timer1_ovf),
		.timer2_ovf(timer2_ovf), .ext_start_pin(ext_start_pin),
		.sar_done(sar_done), .sar_data(sar_data),
		.window_match(window_match), .conv_enable(conv_enable),
		.burst_mode_on(burst_mode_on), .conv_start(conv_start),
		.conv_busy(conv_busy), .conv_done_flag(conv_done_flag),
		.window_match_flag(window_match_flag),
		.result_high(result_high), .result_low(result_low)
	);

	// Free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			complete_run();
		end
	end

	// Prints the verdict and ends the run
	task automatic complete_run();
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// One register write; the strobe is held across exactly one edge
	task automatic wr(input logic [7:0] d);
		@(posedge core_clk); #1;
		sfr_addr = ADCC_CONTROL_ADDR;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge core_clk); #1;
		sfr_wr = 1'b0;
	endtask

	// One register read; data is registered, so it is taken a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk); #1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge core_clk); #1;
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	// Single-cycle trigger: 0 timer 1, 1 pin edge, 2 timer 2, 3 window
	task automatic pulse(input int k);
		@(posedge core_clk); #1;
		timer1_ovf = (k == 0);
		ext_start_pin = (k == 1);
		timer2_ovf = (k == 2);
		window_match = (k == 3);
		@(posedge core_clk); #1;
		{timer1_ovf, ext_start_pin, timer2_ovf, window_match} = 4'h0;
	endtask

	// End a running conversion and check the placed result bytes
	task automatic conv(input logic [11:0] d, input logic lj);
		@(posedge core_clk); #1;
		sar_done = 1'b1;
		sar_data = d;
		@(posedge core_clk); #1;
		sar_done = 1'b0;
		`CHECK(conv_busy, 1'b0)
		`CHECK(conv_done_flag, 1'b1)
		`CHECK(result_high, lj ? d[11:4] : {4'h0, d[11:8]})
		`CHECK(result_low, lj ? {d[3:0], 4'h0} : d[7:0])
	endtask

	// Main sequence
	initial begin
		{rstn, sfr_wr, sfr_rd, timer1_ovf, timer2_ovf} = 5'h0;
		{ext_start_pin, sar_done, window_match} = 3'h0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sar_data = 12'h000;
		repeat (12) @(posedge core_clk);
		#1 rstn = 1'b1;
		rd(ADCC_CONTROL_ADDR, v);
		`CHECK(v, ADCC_CONTROL_RESET)
		rd(8'h55, v);
		`CHECK(v, 8'h00)
		// Triggers while shut down must be dropped
		wr(8'h01);
		pulse(0);
		`CHECK(conv_busy, 1'b0)
		// First write selects source 00, second is a real start request
		wr(8'h10);
		wr(8'h10);
		`CHECK(conv_busy, 1'b0)
		`CHECK(conv_enable, 1'b0)
		wr(8'hC0);
		`CHECK(conv_enable, 1'b1)
		`CHECK(burst_mode_on, 1'b1)
		wr(8'h80);
		`CHECK(burst_mode_on, 1'b0)
		// Software start, then a zero write to busy mid-conversion
		wr(8'h90);
		`CHECK(conv_start, 1'b1)
		`CHECK(conv_busy, 1'b1)
		wr(8'h80);
		`CHECK(conv_busy, 1'b1)
		conv(12'hABC, 1'b0);
		rd(ADCC_CONTROL_ADDR, v);
		`CHECK(v, 8'hA0)
		// Left justify is selected, then a software start checks the left-justified result bytes
		wr(8'h84);
		wr(8'h94);
		conv(12'hABC, 1'b1);
		wr(8'h80);
		`CHECK(conv_done_flag, 1'b0)
		// Busy write with a hardware source selected must not start
		wr(8'h81);
		wr(8'h91);
		`CHECK(conv_busy, 1'b0)
		// Each hardware source code (01 to 11) against every hardware trigger
		for (int s = 1; s < 4; s++) begin
			wr(8'h80 | s[7:0]);
			for (int k = 0; k < 3; k++) begin
				code = 2'(k + 1);
				pulse(k);
				`CHECK(conv_busy, (code == 2'(s)))
				if (code == 2'(s)) conv(12'h123, 1'b0);
			end
		end
		// Window flag sets, holds, and clears only by software
		pulse(3);
		`CHECK(window_match_flag, 1'b1)
		repeat (20) @(posedge core_clk);
		#1;
		`CHECK(window_match_flag, 1'b1)
		wr(8'h80);
		`CHECK(window_match_flag, 1'b0)
		// A match in the cycle of a software clear still sets the flag
		@(posedge core_clk); #1;
		sfr_wdata = 8'h80;
		{sfr_wr, window_match} = 2'b11;
		@(posedge core_clk); #1;
		{sfr_wr, window_match} = 2'b00;
		`CHECK(window_match_flag, 1'b1)
		// Disabling mid-conversion aborts with no done flag
		wr(8'h80);
		wr(8'h90);
		`CHECK(conv_busy, 1'b1)
		wr(8'h00);
		`CHECK(conv_busy, 1'b0)
		`CHECK(conv_done_flag, 1'b0)
		// Matches are still recorded while the converter is shut down
		pulse(3);
		`CHECK(window_match_flag, 1'b1)
		complete_run();
	end
endmodule // adcc_control_test
`default_nettype wire
